// ==== logic/rrre_defines.svh ====
`ifndef RRRE_DEFINES_SVH
`define RRRE_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction encodings (14-bit program word)
// ----------------------------------------------------------------------
`define RRRE_OP_SWRESET     14'h0001
`define RRRE_OP_RETURN      14'h0008
`define RRRE_OP_RETINT      14'h0009
`define RRRE_MAJ_RETLIT     6'h34
`define RRRE_MAJ_ROTLEFT    6'h0d

// ----------------------------------------------------------------------
// Field positions inside the program word
// ----------------------------------------------------------------------
`define RRRE_MAJ_HI         13
`define RRRE_MAJ_LO         8
`define RRRE_LIT_HI         7
`define RRRE_LIT_LO         0
`define RRRE_DEST_BIT       7
`define RRRE_FADDR_HI       6
`define RRRE_FADDR_LO       0
`define RRRE_MSB            7

// ----------------------------------------------------------------------
// Reset values and destination codes
// ----------------------------------------------------------------------
`define RRRE_PC_RESET       '0
`define RRRE_W_RESET        8'h00
`define RRRE_RIFLAG_RESET   1'h1
`define RRRE_DEST_WREG      1'h0
`define RRRE_DEST_FILE      1'h1

`endif

// ==== logic/rrre_pkg.sv ====
`default_nettype none

package rrre_pkg;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        RRRE_IDLE  = 2'h1,
        RRRE_FLUSH = 2'h2
    } rrre_state_t;

    // Write-back strobe towards the register file
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } rrre_regwr_t;

endpackage

`default_nettype wire

// ==== logic/rrre_exec.sv ====
// Notes on behaviour
// - The software reset instruction requests a full device reset and clears the reset-instruction flag.
// - Return from interrupt pops the stack, loads the program counter from the top entry and leaves status flags alone.
// - Return from interrupt sets the global interrupt enable, bit 7 of the interrupt control register.
// - Return from interrupt is one program word and takes two instruction cycles.
// - Return from subroutine pops the stack into the program counter in two cycles with flags unchanged.
// - Return with literal loads the accumulator with its 8-bit immediate and leaves flags unchanged.
// - Return with literal also loads the program counter from the top of stack and takes two cycles.
// - Rotate left shifts the register through carry, touches only carry and takes one cycle.
// - Rotate left writes the accumulator when the destination bit is 0 and the addressed register when it is 1.
`timescale 1ns/1ps
`default_nettype none
`include "rrre_defines.svh"

module rrre_exec #(
    parameter int PC_W = 15
) (
    input  wire logic              clock,           // Instruction clock, 125 MHz
    input  wire logic              rst,             // Async reset, active high
    input  wire logic              instValid,       // Program word present
    input  wire logic [13:0]       instWord,        // Program word
    input  wire logic [7:0]        fileData,        // Addressed register contents
    input  wire logic [PC_W-1:0]   topStackEntry,   // Stack top, return address
    input  wire logic              gieClear,        // Interrupt entry clears enable
    output logic                   instReady,       // Core can take a word
    output logic [PC_W-1:0]        progCounter,     // Program counter
    output logic [7:0]             wReg,            // Working accumulator
    output logic                   carry,           // Carry status flag
    output logic                   globalIntEnable, // Interrupt control bit 7
    output logic                   resetInstrFlag,  // Power status flag, 0 after sw reset
    output logic                   swResetReq,      // Pulse: device reset request
    output logic                   stackPop,        // Pulse: pop the stack
    output rrre_pkg::rrre_regwr_t  regWr            // Register write-back strobe
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    rrre_pkg::rrre_state_t state_ff;
    rrre_pkg::rrre_state_t nxt_state;
    logic                  instReady_ff;
    logic [PC_W-1:0]       progCounter_ff;
    logic [7:0]            wReg_ff;
    logic                  carry_ff;
    logic                  gie_ff;
    logic                  riFlag_ff;
    logic                  swReset_ff;
    logic                  stackPop_ff;
    rrre_pkg::rrre_regwr_t regWr_ff;

    logic       take;
    logic       isSwReset;
    logic       isRetInt;
    logic       isReturn;
    logic       isRetLit;
    logic       isRotLeft;
    logic       isAnyRet;
    logic       destSel;
    logic [7:0] rotated;

    // Words are only taken while the pipeline is not flushing
    assign take      = instValid && instReady_ff;
    assign isSwReset = instWord == `RRRE_OP_SWRESET;
    assign isRetInt  = instWord == `RRRE_OP_RETINT;
    assign isReturn  = instWord == `RRRE_OP_RETURN;
    assign isRetLit  = instWord[`RRRE_MAJ_HI:`RRRE_MAJ_LO] == `RRRE_MAJ_RETLIT;
    assign isRotLeft = instWord[`RRRE_MAJ_HI:`RRRE_MAJ_LO] == `RRRE_MAJ_ROTLEFT;
    assign isAnyRet  = isRetInt || isReturn || isRetLit;
    assign destSel   = instWord[`RRRE_DEST_BIT];
    // Old carry enters bit zero, old top bit leaves to carry
    assign rotated   = {fileData[`RRRE_MSB-1:0], carry_ff};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Returns spend a second cycle flushing the fetched word
    always_comb begin
        case (state_ff)
            rrre_pkg::RRRE_IDLE: begin
                if (take && isAnyRet) begin
                    nxt_state = rrre_pkg::RRRE_FLUSH;
                end else begin
                    nxt_state = rrre_pkg::RRRE_IDLE;
                end
            end
            rrre_pkg::RRRE_FLUSH: nxt_state = rrre_pkg::RRRE_IDLE;
            default:              nxt_state = rrre_pkg::RRRE_IDLE;
        endcase
    end

    // State and ready flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff     <= rrre_pkg::RRRE_IDLE;
            instReady_ff <= 1'h1;
        end else begin
            state_ff     <= nxt_state;
            instReady_ff <= nxt_state == rrre_pkg::RRRE_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Program counter and stack
    // ------------------------------------------------------------------
    // A software reset restarts from the reset vector
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            progCounter_ff <= `RRRE_PC_RESET;
            stackPop_ff    <= 1'h0;
        end else begin
            stackPop_ff <= take && isAnyRet;
            if (take && isSwReset) begin
                progCounter_ff <= `RRRE_PC_RESET;
            end else if (take && isAnyRet) begin
                progCounter_ff <= topStackEntry;
            end else if (take) begin
                progCounter_ff <= progCounter_ff + PC_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Accumulator and carry
    // ------------------------------------------------------------------
    // Returns never touch carry; only the rotate does
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wReg_ff  <= `RRRE_W_RESET;
            carry_ff <= 1'h0;
        end else if (take) begin
            if (isRetLit) begin
                wReg_ff <= instWord[`RRRE_LIT_HI:`RRRE_LIT_LO];
            end else if (isRotLeft && destSel == `RRRE_DEST_WREG) begin
                wReg_ff <= rotated;
            end
            if (isRotLeft) begin
                carry_ff <= fileData[`RRRE_MSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register write-back
    // ------------------------------------------------------------------
    // One-cycle strobe; the file address range is the 7-bit field
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regWr_ff <= '0;
        end else begin
            regWr_ff.valid <= take && isRotLeft && destSel == `RRRE_DEST_FILE;
            regWr_ff.addr  <= instWord[`RRRE_FADDR_HI:`RRRE_FADDR_LO];
            regWr_ff.data  <= rotated;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enable and reset cause
    // ------------------------------------------------------------------
    // Return from interrupt wins over a same-cycle interrupt entry clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gie_ff <= 1'h0;
        end else if (take && isRetInt) begin
            gie_ff <= 1'h1;
        end else if (gieClear || (take && isSwReset)) begin
            gie_ff <= 1'h0;
        end
    end

    // Flag survives the requested reset so software can read the cause
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            riFlag_ff  <= `RRRE_RIFLAG_RESET;
            swReset_ff <= 1'h0;
        end else begin
            swReset_ff <= take && isSwReset;
            if (take && isSwReset) begin
                riFlag_ff <= 1'h0;
            end
        end
    end

    assign instReady       = instReady_ff;
    assign progCounter     = progCounter_ff;
    assign wReg            = wReg_ff;
    assign carry           = carry_ff;
    assign globalIntEnable = gie_ff;
    assign resetInstrFlag  = riFlag_ff;
    assign swResetReq      = swReset_ff;
    assign stackPop        = stackPop_ff;
    assign regWr           = regWr_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sw_reset_flag_a: assert property (
        take && isSwReset |=> swResetReq && !resetInstrFlag && progCounter == '0)
        else $error("software reset did not request reset and clear flag");

    retint_pc_a: assert property (
        take && isRetInt |=> progCounter == $past(topStackEntry) && stackPop
            && carry == $past(carry))
        else $error("return from interrupt did not load pc from stack");

    retint_gie_a: assert property (
        take && isRetInt |=> globalIntEnable)
        else $error("return from interrupt did not set interrupt enable");

    ret_two_cycle_a: assert property (
        take && (isRetInt || isReturn) |=> !instReady ##1 instReady)
        else $error("return did not take two cycles");

    return_flags_a: assert property (
        take && isReturn |=> progCounter == $past(topStackEntry) && $stable(carry)
            && $stable(wReg))
        else $error("return from subroutine wrong pc or flags");

    retlit_w_a: assert property (
        take && isRetLit |=> wReg == $past(instWord[7:0]) && $stable(carry))
        else $error("return with literal wrong accumulator");

    retlit_pc_a: assert property (
        take && isRetLit |=> progCounter == $past(topStackEntry) ##1 instReady)
        else $error("return with literal wrong pc or length");

    rotate_carry_a: assert property (
        take && isRotLeft |=> carry == $past(fileData[7]) && instReady
            && globalIntEnable == ($past(globalIntEnable) && !$past(gieClear)))
        else $error("rotate left wrong carry or length");

    rotate_dest_a: assert property (
        take && isRotLeft |=> regWr.valid == $past(destSel)
            && (regWr.valid || wReg == {$past(fileData[6:0]), $past(carry)}))
        else $error("rotate left wrong destination");

    rotate_data_a: assert property (
        take && isRotLeft && destSel |=> regWr.data == {$past(fileData[6:0]), $past(carry)})
        else $error("rotate left wrong result bits");

    retint_cov_c:  cover property (take && isRetInt ##2 take);
    rotfile_cov_c: cover property (take && isRotLeft && destSel && carry_ff);
    swreset_cov_c: cover property (take && isSwReset);
    retlit_cov_c:  cover property (take && isRetLit ##2 take && isRotLeft);

endmodule // rrre_exec

`default_nettype wire

// ==== verification/rrre_exec_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rrre_defines.svh"

module rrre_exec_test;
    localparam int PCW = 15;

    // Expected port state one edge after each driven word
    typedef struct packed {
        logic [PCW-1:0]        pc;
        logic [7:0]            w;
        logic                  c;
        logic                  global_interrupt_enable;
        logic                  flag;
        logic                  swr;
        logic                  pop;
        logic                  rdy;
        rrre_pkg::rrre_regwr_t rw;
    } rrre_exp_t;

    logic                  clock, rst, instValid, gieClear, instReady, carry;
    logic                  globalIntEnable, resetInstrFlag, swResetReq, stackPop;
    logic [13:0]           instWord;
    logic [7:0]            fileData, wReg;
    logic [PCW-1:0]        topStackEntry, progCounter;
    rrre_pkg::rrre_regwr_t regWr;
    rrre_exp_t             expQ[$];
    rrre_exp_t             m, e;
    logic [31:0]           seed = 32'hf135;
    int                    num_errors = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    rrre_exec #(.PC_W(PCW)) u_dut (.clock(clock), .rst(rst), .instValid(instValid),
        .instWord(instWord), .fileData(fileData), .topStackEntry(topStackEntry),
        .gieClear(gieClear), .instReady(instReady), .progCounter(progCounter), .wReg(wReg),
        .carry(carry), .globalIntEnable(globalIntEnable), .resetInstrFlag(resetInstrFlag),
        .swResetReq(swResetReq), .stackPop(stackPop), .regWr(regWr));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Drive one cycle at the falling edge and note what the next edge must show
    task automatic step(input logic v, input logic [13:0] wd, input logic [7:0] fd,
                        input logic [PCW-1:0] top_stack_entry, input logic gc);
        logic take;
        logic [7:0] res;
        @(negedge clock);
        instValid = v;
        instWord = wd;
        fileData = fd;
        topStackEntry = top_stack_entry;
        gieClear = gc;
        take = v && m.rdy;  // Words in the flush cycle are dropped silently
        res = {fd[6:0], m.c};
        m.swr = 1'b0;
        m.pop = 1'b0;
        m.rdy = 1'b1;
        m.rw = '0;
        if (gc) m.global_interrupt_enable = 1'b0;
        if (take) begin
            if (wd == `RRRE_OP_SWRESET) begin
                m.swr = 1'b1;
                m.flag = 1'b0;
                m.pc = '0;
                m.global_interrupt_enable = 1'b0;
            end else if (wd == `RRRE_OP_RETURN || wd == `RRRE_OP_RETINT ||
                         wd[13:8] == `RRRE_MAJ_RETLIT) begin
                m.pc = top_stack_entry;
                m.pop = 1'b1;
                m.rdy = 1'b0;
                if (wd == `RRRE_OP_RETINT) m.global_interrupt_enable = 1'b1;
                if (wd[13:8] == `RRRE_MAJ_RETLIT) m.w = wd[7:0];
            end else begin
                m.pc = m.pc + 1'b1;
                if (wd[13:8] == `RRRE_MAJ_ROTLEFT) begin
                    m.c = fd[7];
                    if (wd[7]) m.rw = {1'b1, wd[6:0], res};
                    else m.w = res;
                end
            end
        end
        expQ.push_back(m);
    endtask

    // ------------------------------------------------------------------
    // Output watcher and hang guard
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        #1;
        if (expQ.size() > 0) begin
            e = expQ.pop_front();
            check(32'(progCounter), 32'(e.pc));
            check(32'(wReg), 32'(e.w));
            check(32'(carry), 32'(e.c));
            check(32'(globalIntEnable), 32'(e.global_interrupt_enable));
            check(32'(resetInstrFlag), 32'(e.flag));
            check(32'(swResetReq), 32'(e.swr));
            check(32'(stackPop), 32'(e.pop));
            check(32'(instReady), 32'(e.rdy));
            check(32'(regWr.valid), 32'(e.rw.valid));
            if (e.rw.valid) check(32'(regWr), 32'(e.rw));
        end
    end

    // Whole run is about 65 cycles; the ceiling of 3000 leaves wide margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("ERROR at %0t: run did not finish", $time);
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [13:0] wd;
        rst = 1'b1;
        {instValid, instWord, fileData, topStackEntry, gieClear} = '0;
        m = '0;
        m.flag = 1'b1;
        m.rdy = 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        // Worked rotate: old carry 0 and source e6 give cc with carry set
        step(1'b1, {`RRRE_MAJ_ROTLEFT, 8'h05}, 8'he6, '0, 1'b0);
        // Rotates mixed with major 3f filler words, both destinations, random file addresses
        for (int i = 0; i < 30; i++) begin
            r = xs();
            wd = r[20] ? {`RRRE_MAJ_ROTLEFT, r[7:0]} : {6'h3f, r[7:0]};
            step(1'b1, wd, r[15:8], '0, r[16]);
        end
        // Each return kind, literal boundaries, a refused word in every flush
        for (int i = 0; i < 6; i++) begin
            r = xs();
            case (i % 3)
                0: wd = `RRRE_OP_RETINT;
                1: wd = `RRRE_OP_RETURN;
                default: wd = {`RRRE_MAJ_RETLIT, (i == 2) ? 8'h00 : 8'hff};
            endcase
            step(1'b0, 14'h0000, 8'h00, '0, 1'b1);
            step(1'b1, wd, 8'h00, r[PCW-1:0], i == 3);
            step(1'b1, {`RRRE_MAJ_ROTLEFT, 8'h80}, 8'hff, '0, 1'b0);
        end
        // Software reset with interrupts enabled, then ordinary words at once
        step(1'b1, `RRRE_OP_RETINT, 8'h00, 15'h5a5a, 1'b0);
        step(1'b0, 14'h0000, 8'h00, '0, 1'b0);
        step(1'b1, `RRRE_OP_SWRESET, 8'h00, '0, 1'b0);
        step(1'b1, 14'h0000, 8'h00, '0, 1'b0);
        step(1'b1, {`RRRE_MAJ_ROTLEFT, 8'hff}, 8'h7f, '0, 1'b0);
        step(1'b0, 14'h0000, 8'h00, '0, 1'b0);
        // Mid-run reset: only a real reset may bring the reset-cause flag back to 1
        @(negedge clock) rst = 1'b1;
        @(negedge clock) rst = 1'b0;
        m = '0;
        m.flag = 1'b1;
        m.rdy = 1'b1;
        step(1'b0, 14'h0000, 8'h00, '0, 1'b0);
        repeat (3) @(posedge clock);
        finish_test();
    end
endmodule // rrre_exec_test

`default_nettype wire
